// ===== src/bfp_log_if.sv
// Write and read path between the control logic and the log memory
interface bfp_log_if;
   logic                    wr_en;
   logic [3:0]              wr_addr;
   bfp_pkg::bfp_log_entry_s wr_data;
   logic [3:0]              rd_addr;
   bfp_pkg::bfp_log_entry_s rd_data;

   modport ctrl (output wr_en, output wr_addr, output wr_data,
                 output rd_addr, input rd_data);
   modport mem  (input wr_en, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface : bfp_log_if

// ===== src/bfp_log_mem.sv
// Twelve-entry operation log storage with registered read data
`include "bfp_regs.svh"

module bfp_log_mem (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   // Log path
   bfp_log_if.mem    bus
);

   bfp_pkg::bfp_log_entry_s mem_r [`BFP_LOG_DEPTH];

   // Write port; slots past the last are never addressed
   always_ff @(posedge ref_clk_i) begin
      if (bus.wr_en) begin
         mem_r[bus.wr_addr] <= bus.wr_data;
      end
   end

   // Registered read, zero for an out-of-range slot
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus.rd_data <= '0;
      end else if (bus.rd_addr <= `BFP_LOG_LAST) begin
         bus.rd_data <= mem_r[bus.rd_addr];
      end else begin
         bus.rd_data <= '0;
      end
   end

endmodule : bfp_log_mem

// ===== src/bfp_pkg.sv
// Types shared by the breaker failure supervision block
package bfp_pkg;

   // Start criterion selection
   typedef enum logic [1:0] {
      BFP_CRIT_CURRENT,
      BFP_CRIT_CUR_AND_TRIP,
      BFP_CRIT_CUR_OR_TRIP,
      BFP_CRIT_DIG_IN
   } bfp_crit_e;

   // Monitored signals, in event index order
   typedef enum logic [2:0] {
      BFP_SIG_START,
      BFP_SIG_RETRIP,
      BFP_SIG_FAIL,
      BFP_SIG_BLOCK,
      BFP_SIG_TRIP_MON,
      BFP_SIG_INPUT,
      BFP_SIG_PHASE,
      BFP_SIG_RESID
   } bfp_sig_e;

   // One operation log entry
   typedef struct packed {
      logic [63:0] stamp;
      logic [3:0]  event_code;
      logic [15:0] phase_max;
      logic [15:0] resid;
      logic [18:0] to_retrip;
      logic [18:0] to_fail;
      logic [2:0]  setting_group;
   } bfp_log_entry_s;

endpackage : bfp_pkg

// ===== src/bfp_regs.svh
// Constants of the breaker failure supervision block
`ifndef BFP_REGS_SVH
`define BFP_REGS_SVH

// Timing
`define BFP_CLK_NS          10
`define BFP_STEP_MS         5
`define BFP_FAIL_DLY_MS     200
`define BFP_RETRIP_DLY_MS   100
`define BFP_NS_PER_MS       1000000

// Reset values of the settings
`define BFP_RETRIP_EN_RST   1'b1
`define BFP_EVT_EN_RST      8'hFF

// Operation log
`define BFP_LOG_DEPTH       12
`define BFP_LOG_LAST        4'hB

// Condition codes
`define BFP_COND_NORMAL     3'h0
`define BFP_COND_START      3'h1
`define BFP_COND_RETRIP     3'h2
`define BFP_COND_FAIL       3'h3
`define BFP_COND_BLOCKED    3'h4

`endif

// ===== src/bfp_top.sv
// Breaker failure supervision: timers, outputs, events and log
`include "bfp_regs.svh"

module bfp_top #(
   parameter int DLY_W       = 19,
   parameter int TICK_CYCLES =
      (`BFP_STEP_MS * `BFP_NS_PER_MS) / `BFP_CLK_NS
) (
   // Clock and reset
   input  wire logic               ref_clk_i,
   input  wire logic               rstn_i,
   // Settings
   input  wire logic [1:0]         criterion_i,
   input  wire logic               cur_sup_en_i,
   input  wire logic               do_sup_en_i,
   input  wire logic               cfg_wr_i,
   input  wire logic               retrip_en_i,
   input  wire logic [DLY_W-1:0]   fail_dly_i,
   input  wire logic [DLY_W-1:0]   redundant_trip_delay_i,
   input  wire logic [7:0]         evt_on_en_i,
   input  wire logic [7:0]         evt_off_en_i,
   // Measurement and process data
   input  wire logic               phase_over_i,
   input  wire logic               resid_over_i,
   input  wire logic [15:0]        phase_max_i,
   input  wire logic [15:0]        resid_cur_i,
   input  wire logic [2:0]         setting_group_i,
   input  wire logic [63:0]        time_stamp_i,
   // Trip and block sources
   input  wire logic               trip_cur_i,
   input  wire logic               trip_any_i,
   input  wire logic               block_i,
   input  wire logic               dig_trip_i,
   // Protection outputs
   output logic                    start_o,
   output logic                    redundant_trip_o,
   output logic                    breaker_fail_command_o,
   output logic                    blocked_o,
   output logic [2:0]              condition_o,
   // Event stream to the main buffer
   output logic                    evt_valid_o,
   output logic [3:0]              evt_code_o,
   output logic [63:0]             evt_stamp_o,
   output logic [15:0]             evt_phase_o,
   output logic [15:0]             evt_resid_o,
   // Operation log
   input  wire logic [3:0]         log_rd_slot_i,
   output bfp_pkg::bfp_log_entry_s log_rd_data_o,
   output logic [3:0]              log_head_o,
   output logic [3:0]              log_count_o
);

   localparam int TICK_W = $clog2(TICK_CYCLES + 1);
   localparam logic [DLY_W-1:0] FAIL_DEF =
      DLY_W'(`BFP_FAIL_DLY_MS / `BFP_STEP_MS);
   localparam logic [DLY_W-1:0] RETRIP_DEF =
      DLY_W'(`BFP_RETRIP_DLY_MS / `BFP_STEP_MS);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   // Remaining steps until a delay runs out
   function automatic logic [DLY_W-1:0] remain(
      input logic [DLY_W-1:0] dly, input logic [DLY_W-1:0] cnt);
      return (cnt >= dly) ? '0 : DLY_W'(dly - cnt);
   endfunction : remain

   // Lowest pending bit: {found, index}
   function automatic logic [4:0] first_set(input logic [15:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction : first_set

   ////////////////////////////////////////////////////////////////////
   // Reset release and input synchronisation

   logic rst_s1_r, rst_n;
   logic dig_s1_r, dig_s2_r;

   // Reset is released through two flops
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   // External trip pin is asynchronous to this clock
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dig_s1_r <= 1'b0;
         dig_s2_r <= 1'b0;
      end else begin
         dig_s1_r <= dig_trip_i;
         dig_s2_r <= dig_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Settings and processing tick

   logic [DLY_W-1:0]  fail_dly_r, retrip_dly_r;
   logic              retrip_en_r;
   logic [TICK_W-1:0] tick_cnt_r;
   logic              tick_r;

   // Delays load on a write strobe, documented defaults at reset
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fail_dly_r   <= FAIL_DEF;
         retrip_dly_r <= RETRIP_DEF;
         retrip_en_r  <= `BFP_RETRIP_EN_RST;
      end else if (cfg_wr_i) begin
         fail_dly_r   <= fail_dly_i;
         retrip_dly_r <= redundant_trip_delay_i;
         retrip_en_r  <= retrip_en_i;
      end
   end

   // One tick per 5 ms step shared by both timers
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
      end else begin
         tick_r     <= (tick_cnt_r == TICK_LAST);
         tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0
                       : TICK_W'(tick_cnt_r + 1'b1);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Start criteria

   bfp_pkg::bfp_crit_e crit;
   logic cur_above, trip_mon, pick, run, timer_run;

   assign crit      = bfp_pkg::bfp_crit_e'(criterion_i);
   assign cur_above = phase_over_i | resid_over_i;
   // And mode sees only current-based trips, others see every trip
   assign trip_mon  = (crit == bfp_pkg::BFP_CRIT_CUR_AND_TRIP)
                      ? trip_cur_i : trip_any_i;
   // Pick-up element per criterion
   assign pick = (crit == bfp_pkg::BFP_CRIT_DIG_IN) ? dig_s2_r
               : (crit == bfp_pkg::BFP_CRIT_CUR_OR_TRIP)
                 ? (cur_above | trip_mon)
               : cur_above;
   // Condition that lets the timers run
   assign run  = (crit == bfp_pkg::BFP_CRIT_CURRENT) ? cur_above
               : (crit == bfp_pkg::BFP_CRIT_CUR_AND_TRIP)
                 ? (cur_above & trip_mon)
               : (crit == bfp_pkg::BFP_CRIT_CUR_OR_TRIP)
                 ? (cur_above | trip_mon)
               : (dig_s2_r & (~cur_sup_en_i | cur_above)
                  & (~do_sup_en_i | trip_mon));
   // A block stops all timing and releases an active start
   assign timer_run = run & ~block_i;

   ////////////////////////////////////////////////////////////////////
   // Delay timer and protection outputs

   logic [DLY_W-1:0] cnt_r, cnt_nxt;
   logic start_r, retrip_r, fail_r, blocked_r;
   logic [2:0] cond_r, cond_nxt;

   // One elapsed-step counter serves both delays, so they share pick-up
   assign cnt_nxt = !timer_run ? '0
                  : (tick_r && !(&cnt_r)) ? DLY_W'(cnt_r + 1'b1)
                  : cnt_r;

   assign cond_nxt = (pick & block_i)           ? `BFP_COND_BLOCKED
                   : (timer_run && cnt_r >= fail_dly_r) ? `BFP_COND_FAIL
                   : (timer_run && retrip_en_r && cnt_r >= retrip_dly_r)
                                                ? `BFP_COND_RETRIP
                   : (pick & ~block_i)          ? `BFP_COND_START
                   : `BFP_COND_NORMAL;

   // Outputs are registered from the same cycle's decisions
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r     <= '0;
         start_r   <= 1'b0;
         retrip_r  <= 1'b0;
         fail_r    <= 1'b0;
         blocked_r <= 1'b0;
         cond_r    <= `BFP_COND_NORMAL;
      end else begin
         cnt_r     <= cnt_nxt;
         start_r   <= pick & ~block_i;
         blocked_r <= pick & block_i;
         retrip_r  <= timer_run & retrip_en_r
                      & (cnt_r >= retrip_dly_r);
         fail_r    <= timer_run & (cnt_r >= fail_dly_r);
         cond_r    <= cond_nxt;
      end
   end

   assign start_o                = start_r;
   assign redundant_trip_o       = retrip_r;
   assign breaker_fail_command_o = fail_r;
   assign blocked_o              = blocked_r;
   assign condition_o            = cond_r;

   ////////////////////////////////////////////////////////////////////
   // Events

   logic [7:0]  sig_now, sig_prev_r, rise, fall;
   logic [15:0] evt_set, log_set, evt_pend_r, log_pend_r;
   logic [4:0]  evt_pick, log_pick;
   logic [15:0] evt_clr, log_clr;

   assign sig_now = {resid_over_i, phase_over_i, dig_s2_r, trip_mon,
                     blocked_r, fail_r, retrip_r, start_r};
   assign rise    = sig_now & ~sig_prev_r;
   assign fall    = ~sig_now & sig_prev_r;

   // Even bit is ON, odd bit OFF; log wants every ON edge
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         evt_set[2*k]   = rise[k] & evt_on_en_i[k];
         evt_set[2*k+1] = fall[k] & evt_off_en_i[k];
         log_set[2*k]   = rise[k];
         log_set[2*k+1] = 1'b0;
      end
   end

   // Several edges may coincide, so they queue and drain one per cycle
   assign evt_pick = first_set(evt_pend_r);
   assign log_pick = first_set(log_pend_r);
   assign evt_clr  = evt_pick[4] ? (16'h0001 << evt_pick[3:0]) : '0;
   assign log_clr  = log_pick[4] ? (16'h0001 << log_pick[3:0]) : '0;

   // New edges win over the clear of the bit just served
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sig_prev_r <= '0;
         evt_pend_r <= '0;
         log_pend_r <= '0;
      end else begin
         sig_prev_r <= sig_now;
         evt_pend_r <= (evt_pend_r & ~evt_clr) | evt_set;
         log_pend_r <= (log_pend_r & ~log_clr) | log_set;
      end
   end

   // Served event leaves with stamp and process data
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         evt_valid_o <= 1'b0;
         evt_code_o  <= '0;
         evt_stamp_o <= '0;
         evt_phase_o <= '0;
         evt_resid_o <= '0;
      end else begin
         evt_valid_o <= evt_pick[4];
         evt_code_o  <= evt_pick[3:0];
         evt_stamp_o <= time_stamp_i;
         evt_phase_o <= phase_max_i;
         evt_resid_o <= resid_cur_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Operation log

   bfp_log_if log_bus ();
   logic [3:0] head_r, count_r;

   assign log_bus.wr_en   = log_pick[4];
   assign log_bus.wr_addr = head_r;
   assign log_bus.rd_addr = log_rd_slot_i;
   assign log_bus.wr_data = '{stamp:         time_stamp_i,
                              event_code:    log_pick[3:0],
                              phase_max:     phase_max_i,
                              resid:         resid_cur_i,
                              to_retrip:     remain(retrip_dly_r, cnt_r),
                              to_fail:       remain(fail_dly_r, cnt_r),
                              setting_group: setting_group_i};

   // Head wraps after the last slot, overwriting the oldest entry
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         head_r  <= '0;
         count_r <= '0;
      end else if (log_pick[4]) begin
         head_r  <= (head_r == `BFP_LOG_LAST) ? '0
                    : 4'(head_r + 1'b1);
         count_r <= (count_r == 4'(`BFP_LOG_DEPTH)) ? count_r
                    : 4'(count_r + 1'b1);
      end
   end

   bfp_log_mem u_log_mem (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n),
      .bus       (log_bus)
   );

   assign log_rd_data_o = log_bus.rd_data;
   assign log_head_o    = head_r;
   assign log_count_o   = count_r;

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n);

   a_cur_only_start: assert property (
      (crit == bfp_pkg::BFP_CRIT_CURRENT) && cur_above && !block_i
      |=> start_o) else $error("current mode start missing");
   a_cur_drop_clear: assert property (
      (crit == bfp_pkg::BFP_CRIT_CURRENT) && !cur_above
      |=> cnt_r == '0 ##1 !breaker_fail_command_o)
      else $error("current drop did not clear timer");
   a_and_hold_off: assert property (
      (crit == bfp_pkg::BFP_CRIT_CUR_AND_TRIP) && cur_above && !trip_mon
      |=> cnt_r == '0) else $error("and mode counted without trip");
   a_and_reset_cmd: assert property (
      (crit == bfp_pkg::BFP_CRIT_CUR_AND_TRIP) && !(cur_above && trip_mon)
      |=> !breaker_fail_command_o) else $error("and mode command held");
   a_or_reset_both: assert property (
      (crit == bfp_pkg::BFP_CRIT_CUR_OR_TRIP) && !cur_above && !trip_mon
      |=> cnt_r == '0 && !start_o) else $error("or mode not reset");
   a_fail_needs_start: assert property (
      breaker_fail_command_o |-> start_o && !blocked_o)
      else $error("command without start");
   a_block_drops_start: assert property (
      pick && block_i |=> blocked_o && !start_o && cnt_r == '0)
      else $error("block did not override start");
   a_cond_blocked: assert property (
      blocked_o |-> condition_o == `BFP_COND_BLOCKED)
      else $error("condition code wrong when blocked");
   a_retrip_disabled: assert property (
      !retrip_en_r |=> !redundant_trip_o)
      else $error("redundant trip while disabled");
   a_count_on_tick: assert property (
      cnt_r != $past(cnt_r) && cnt_r != '0 |-> $past(tick_r))
      else $error("timer stepped without tick");
   a_log_wraps: assert property (
      log_bus.wr_en && head_r == `BFP_LOG_LAST |=> head_r == '0)
      else $error("log head did not wrap");

endmodule : bfp_top

// ===== test/bfp_far_end.sv
// Model of the primary protection stage, its breaker and the incomer
module bfp_far_end #(
   parameter int LAG = 15
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Scenario controls from the bench and the block's failure command
   input  wire logic fault_i,
   input  wire logic over_i,
   input  wire logic res_i,
   input  wire logic trip_en_i,
   input  wire logic cur_fn_i,
   input  wire logic brk_ok_i,
   input  wire logic fail_cmd_i,
   // Toward the supervision block
   output logic      phase_over_o,
   output logic      resid_over_o,
   output logic      trip_cur_o,
   output logic      trip_any_o
);
   timeunit 1ns;
   timeprecision 100ps;

   int   age_r;
   logic trip_r;
   logic cleared_r;
   logic incomer_r;

   ////////////////////////////////////////////////////////////////////////
   // Primary trip comes a fixed lag after the fault; a healthy breaker
   // then clears the current, the incomer opens on the failure command
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         age_r     <= 0;
         trip_r    <= 1'b0;
         cleared_r <= 1'b0;
         incomer_r <= 1'b0;
      end else if (!fault_i) begin
         age_r     <= 0;
         trip_r    <= 1'b0;
         cleared_r <= 1'b0;
         incomer_r <= 1'b0;
      end else begin
         if (age_r < LAG) age_r <= age_r + 1;
         trip_r <= trip_en_i && (age_r >= LAG - 1);
         if (trip_r && brk_ok_i) cleared_r <= 1'b1;
         if (fail_cmd_i) incomer_r <= 1'b1;
      end
   end

   // Comparators drop once either breaker has interrupted the current
   assign phase_over_o = fault_i & over_i & ~cleared_r & ~incomer_r;
   assign resid_over_o = fault_i & res_i & ~cleared_r & ~incomer_r;
   assign trip_any_o   = trip_r & ~incomer_r;
   assign trip_cur_o   = trip_r & ~incomer_r & cur_fn_i;
endmodule : bfp_far_end

// ===== test/tb_top.sv
// Self-checking bench for the breaker failure supervision block
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int TK = 10;  // Short tick keeps every timer run brief

   typedef struct {
      int   crit;
      logic over, res, tr, cf, bok, dig, csup, dsup, fail;
      int   lo, hi;
   } bfp_row_s;

   logic        clk = 1'b0, rstn = 1'b0, cfg_wr = 1'b0, ret_en = 1'b0;
   logic        csup = 1'b0, blk = 1'b0, dig = 1'b0, dsup = 1'b0;
   logic [1:0]  crit = 2'h0;
   logic [18:0] fdly = 19'h0_0000, rdly = 19'h0_0000;
   logic [63:0] ts = 64'h0000_0000_0000_0000;
   logic [15:0] ph = 16'h0000;
   logic [3:0]  slot = 4'h0;
   logic        pf_fault = 1'b0, pf_over = 1'b0, pf_res = 1'b0;
   logic        pf_tr = 1'b0, pf_cf = 1'b0, pf_bok = 1'b0;
   logic        phase_over, resid_over, trip_cur, trip_any;
   logic        start, retrip, fail, blocked, ev_valid;
   logic [2:0]  cond;
   logic [3:0]  ev_code, head, count;
   logic [63:0] ev_stamp, last_stamp = 64'h0000_0000_0000_0000;
   logic [15:0] ev_phase, last_phase = 16'h0000, ev_seen = 16'h0000;
   logic [15:0] ev_resid, last_resid = 16'h0000;
   bfp_pkg::bfp_log_entry_s log_data;
   int          err_total = 0, compares = 0, cyc = 0;
   bfp_row_s    rows[13];

   ////////////////////////////////////////////////////////////////////////
   // Design and far end
   bfp_top #(.TICK_CYCLES(TK)) i_bfp_top (
      .ref_clk_i(clk), .rstn_i(rstn), .criterion_i(crit),
      .cur_sup_en_i(csup), .do_sup_en_i(dsup), .cfg_wr_i(cfg_wr),
      .retrip_en_i(ret_en), .fail_dly_i(fdly),
      .redundant_trip_delay_i(rdly), .evt_on_en_i(8'h7f),
      .evt_off_en_i(8'hfe), .phase_over_i(phase_over),
      .resid_over_i(resid_over), .phase_max_i(ph),
      .resid_cur_i(16'h0042), .setting_group_i(3'h5),
      .time_stamp_i(ts), .trip_cur_i(trip_cur), .trip_any_i(trip_any),
      .block_i(blk), .dig_trip_i(dig), .start_o(start),
      .redundant_trip_o(retrip), .breaker_fail_command_o(fail),
      .blocked_o(blocked), .condition_o(cond), .evt_valid_o(ev_valid),
      .evt_code_o(ev_code), .evt_stamp_o(ev_stamp),
      .evt_phase_o(ev_phase), .evt_resid_o(ev_resid),
      .log_rd_slot_i(slot), .log_rd_data_o(log_data),
      .log_head_o(head), .log_count_o(count)
   );

   bfp_far_end i_bfp_far_end (
      .clk_i(clk), .rstn_i(rstn), .fault_i(pf_fault), .over_i(pf_over),
      .res_i(pf_res), .trip_en_i(pf_tr), .cur_fn_i(pf_cf),
      .brk_ok_i(pf_bok), .fail_cmd_i(fail), .phase_over_o(phase_over),
      .resid_over_o(resid_over), .trip_cur_o(trip_cur),
      .trip_any_o(trip_any)
   );

   // Clock
   always #5 clk = ~clk;

   // Event stream is sampled mid-cycle, where the pulse has settled
   always @(negedge clk) begin
      if (ev_valid === 1'b1) begin
         ev_seen[ev_code] = 1'b1;
         last_stamp = ev_stamp;
         last_phase = ev_phase;
         last_resid = ev_resid;
      end
   end

   // Hang guard, well above the roughly 1200 cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [63:0] seen,
                      input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic print_verdict();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   // One fault case: raise it, wait for the command, clear and settle
   task automatic run_row(input bfp_row_s r, input int k);
      int n;
      n = 0;
      crit = r.crit[1:0];
      csup = r.csup;
      dsup = r.dsup;
      {pf_over, pf_res, pf_tr, pf_cf, pf_bok} =
         {r.over, r.res, r.tr, r.cf, r.bok};
      ts = 64'h0000_0000_0000_0100 + 64'(k);
      ph = 16'h0100 + 16'(k);
      pf_fault = 1'b1;
      dig = r.dig;
      while (fail !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk("fail_cmd", fail, r.fail);
      if (r.fail) begin
         chk("fail_time", n >= r.lo && n <= r.hi, 1'b1);
         chk("retrip_on", retrip, 1'b1);
         chk("cond_fail", cond, 3'h3);
      end
      pf_fault = 1'b0;
      dig = 1'b0;
      repeat (12) @(negedge clk);
      chk("idle", {start, retrip, fail, cond}, 6'h00);
      chk("ev_stamp", last_stamp, ts);
      chk("ev_phase", last_phase, ph);
      chk("ev_resid", last_resid, 16'h0042);
   endtask : run_row

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rows[0]  = '{0, 1, 0, 0, 0, 0, 0, 0, 0, 1, 30, 46};
      rows[1]  = '{0, 0, 1, 0, 0, 0, 0, 0, 0, 1, 30, 46};
      rows[2]  = '{0, 1, 0, 1, 1, 1, 0, 0, 0, 0, 0, 0};
      rows[3]  = '{1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
      rows[4]  = '{1, 1, 0, 1, 1, 0, 0, 0, 0, 1, 45, 62};
      rows[5]  = '{1, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0};
      rows[6]  = '{1, 1, 0, 1, 1, 1, 0, 0, 0, 0, 0, 0};
      rows[7]  = '{2, 0, 0, 1, 0, 0, 0, 0, 0, 1, 45, 62};
      rows[8]  = '{2, 1, 0, 1, 1, 1, 0, 0, 0, 1, 30, 46};
      rows[9]  = '{3, 0, 0, 0, 0, 0, 1, 0, 0, 1, 31, 49};
      rows[10] = '{3, 0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0};
      // Trip supervision in input mode: no trip holds off, trip lets run
      rows[11] = '{3, 0, 0, 0, 0, 0, 1, 0, 1, 0, 0, 0};
      rows[12] = '{3, 0, 0, 1, 0, 0, 1, 0, 1, 1, 45, 62};
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      chk("reset_state", {count, cond, fail}, 8'h00);
      fdly = 19'h0_0004;
      rdly = 19'h0_0002;
      ret_en = 1'b1;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
      foreach (rows[k]) run_row(rows[k], k);
      // Block arriving while started releases start and holds off timing
      crit = 2'h0;
      {pf_over, pf_res, pf_tr, pf_cf, pf_bok} = 5'b10000;
      ts = 64'h0000_0000_0000_0200;
      ph = 16'h0200;
      pf_fault = 1'b1;
      repeat (3) @(negedge clk);
      chk("start_on", {start, cond}, 4'h9);
      blk = 1'b1;
      repeat (3) @(negedge clk);
      chk("blocked", {start, blocked, cond}, 5'h0c);
      repeat (60) @(negedge clk);
      chk("block_fail", fail, 1'b0);
      pf_fault = 1'b0;
      blk = 1'b0;
      repeat (12) @(negedge clk);
      // Log holds only the newest twelve; newest is the block entry
      chk("log_count", count, 4'hc);
      chk("log_head", head < 4'hc, 1'b1);
      slot = (head == 4'h0) ? 4'hb : head - 4'h1;
      repeat (2) @(negedge clk);
      chk("log_stamp", log_data.stamp, ts);
      chk("log_phase", log_data.phase_max, ph);
      chk("log_group", log_data.setting_group, 3'h5);
      chk("log_code", log_data.event_code, 4'h6);
      chk("log_resid", log_data.resid, 16'h0042);
      chk("log_to_fail", log_data.to_fail, fdly);
      chk("log_to_retrip", log_data.to_retrip, rdly);
      // Start OFF and residual ON are filtered out of the event stream
      chk("ev_mask", ev_seen, 16'hbffd);
      print_verdict();
   end
endmodule : tb_top
